// file: common/cmp_filter_defines.svh
// Register offsets, field positions, reset values and constants of the comparator output filter
`ifndef CMP_FILTER_DEFINES_SVH
`define CMP_FILTER_DEFINES_SVH

// ==========================================================================
// Register byte offsets
`define CTRL_OFFSET 12'h000
`define PERIOD_OFFSET 12'h004
`define STATUS_OFFSET 12'h008

// ==========================================================================
// Control register fields
`define CTRL_EN_BIT 0
`define CTRL_WIN_BIT 1
`define CTRL_SAMPLE_SEL_BIT 2
`define CTRL_INVERT_BIT 3
`define CTRL_CNT_LSB 8
`define CTRL_CNT_W 3

// ==========================================================================
// Status register fields
`define STAT_OUT_BIT 0
`define STAT_FALL_BIT 1
`define STAT_RISE_BIT 2
`define STAT_FALL_IE_BIT 3
`define STAT_RISE_IE_BIT 4
`define STAT_RAW_BIT 5

// ==========================================================================
// Reset values and limits
`define CTRL_RESET 32'h0000_0000
`define PERIOD_RESET 8'h00
`define CNT_ONE 3'h1
`define PERIOD_W 8

`endif

// file: common/cmp_filter_pkg.sv
// Types shared by the comparator output filter
package cmp_filter_pkg;
  typedef enum logic [4:0] {
    MODE_OFF = 5'b00001,
    MODE_CONT = 5'b00010,
    MODE_SAMPLE = 5'b00100,
    MODE_FILTER = 5'b01000,
    MODE_WINDOW = 5'b10000
  } filt_mode_t;
endpackage

// file: src/cmp_sync3.sv
// Three-stage synchroniser with agreement on the last two stages
`timescale 1ns/1ps
`default_nettype none
module cmp_sync3 (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic din,
  output logic dout
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // Output moves only once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        dout <= s3_reg;
      end
    end
  end
endmodule // cmp_sync3
`default_nettype wire

// file: src/cmp_out_filter.sv
// Comparator output window, sample filter, edge flags and APB registers
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "cmp_filter_defines.svh"
module cmp_out_filter
  import cmp_filter_pkg::*;
#(
  parameter int CNT_W = `CTRL_CNT_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic compare_in,
  input wire logic window_in,
  input wire logic sample_in,
  output logic raw_compare_out,
  output logic filtered_out,
  output logic irq
);
  // ========================================================================
  // Register bus
  logic [31:0] ctrl_reg;
  logic [`PERIOD_W-1:0] sample_period_div;
  logic rise_flag;
  logic fall_flag;
  logic rise_irq_enable;
  logic fall_irq_enable;

  wire access = psel && penable;
  wire hit_ctrl = paddr == `CTRL_OFFSET;
  wire hit_period = paddr == `PERIOD_OFFSET;
  wire hit_status = paddr == `STATUS_OFFSET;
  wire mapped = hit_ctrl || hit_period || hit_status;
  wire wr = access && pwrite && mapped;
  wire wr_status = wr && hit_status;

  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  wire comp_en = ctrl_reg[`CTRL_EN_BIT];
  wire win_sel = ctrl_reg[`CTRL_WIN_BIT];
  wire ext_sample_select = ctrl_reg[`CTRL_SAMPLE_SEL_BIT];
  wire invert = ctrl_reg[`CTRL_INVERT_BIT];
  wire [CNT_W-1:0] sample_agree_count = ctrl_reg[`CTRL_CNT_LSB +: CNT_W];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `CTRL_RESET;
      sample_period_div <= `PERIOD_RESET;
      rise_irq_enable <= 1'b0;
      fall_irq_enable <= 1'b0;
    end else if (wr) begin
      if (hit_ctrl) begin
        ctrl_reg <= pwdata & 32'h0000_070f;
      end
      if (hit_period) begin
        sample_period_div <= pwdata[`PERIOD_W-1:0];
      end
      if (hit_status) begin
        rise_irq_enable <= pwdata[`STAT_RISE_IE_BIT];
        fall_irq_enable <= pwdata[`STAT_FALL_IE_BIT];
      end
    end
  end

  // ========================================================================
  // Mode decode
  wire cnt_zero = sample_agree_count == '0;
  wire cnt_one = sample_agree_count == CNT_W'(`CNT_ONE);
  wire per_zero = sample_period_div == '0;
  wire src_on = ext_sample_select || !per_zero;
  filt_mode_t mode;
  always_comb begin
    if (!comp_en) begin
      mode = MODE_OFF;
    end else if (win_sel && (cnt_zero || per_zero)) begin
      mode = MODE_WINDOW;
    end else if (cnt_zero || !src_on) begin
      mode = MODE_CONT;
    end else if (cnt_one) begin
      mode = MODE_SAMPLE;
    end else begin
      mode = MODE_FILTER;
    end
  end
  wire filt_active = (mode == MODE_SAMPLE) || (mode == MODE_FILTER);

  // ========================================================================
  // Polarity and window latch
  wire raw_pol = compare_in ^ invert;
  logic win_gate;
  logic win_hold_reg;
  cmp_sync3 u_win_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(window_in),
    .dout(win_gate)
  );
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_hold_reg <= 1'b0;
    end else if (win_gate) begin
      win_hold_reg <= raw_pol;
    end
  end
  // Window applies whenever window select is on, including resampled variants
  wire stage_in = (comp_en && win_sel) ? win_hold_reg : raw_pol;
  assign raw_compare_out = comp_en ? stage_in : 1'b0;

  // ========================================================================
  // Sample clock: divider or synchronized external sample rising edge
  logic samp_s;
  logic samp_d_reg;
  logic [`PERIOD_W-1:0] div_cnt_reg;
  cmp_sync3 u_samp_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(sample_in),
    .dout(samp_s)
  );
  wire div_tick = !ext_sample_select && !per_zero && (div_cnt_reg == sample_period_div - 8'h01);
  wire ext_tick = ext_sample_select && samp_s && !samp_d_reg;
  wire sample_tick = filt_active && (ext_tick || div_tick);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp_d_reg <= 1'b0;
      div_cnt_reg <= '0;
    end else begin
      samp_d_reg <= samp_s;
      if (!filt_active || div_tick || ext_sample_select) begin
        div_cnt_reg <= '0;
      end else begin
        div_cnt_reg <= div_cnt_reg + 8'h01;
      end
    end
  end

  // ========================================================================
  // Raw synchronizer feeding the filter and the edge detector
  logic raw_sync;
  cmp_sync3 u_raw_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(stage_in),
    .dout(raw_sync)
  );

  // ========================================================================
  // Consecutive agreement filter
  logic filt_out_reg;
  logic [CNT_W-1:0] agree_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_out_reg <= 1'b0;
      agree_reg <= '0;
    end else if (!filt_active) begin
      filt_out_reg <= 1'b0;
      agree_reg <= '0;
    end else if (sample_tick) begin
      if (raw_sync == filt_out_reg) begin
        agree_reg <= '0;
      end else if (agree_reg + CNT_W'(1) >= sample_agree_count) begin
        filt_out_reg <= raw_sync;
        agree_reg <= '0;
      end else begin
        agree_reg <= agree_reg + CNT_W'(1);
      end
    end
  end

  // Continuous bypass is combinational; off drives low; window, sample and filter modes use synchronized path
  logic out_sel;
  always_comb begin
    case (mode)
      MODE_CONT: out_sel = raw_pol;
      MODE_WINDOW: out_sel = raw_sync;
      MODE_SAMPLE: out_sel = filt_out_reg;
      MODE_FILTER: out_sel = filt_out_reg;
      default: out_sel = 1'b0;
    endcase
  end
  assign filtered_out = out_sel;

  // ========================================================================
  // Edge flags from the synchronized output
  logic edge_src;
  logic edge_d_reg;
  assign edge_src = (mode == MODE_CONT) ? raw_sync : out_sel;
  wire rise_ev = edge_src && !edge_d_reg;
  wire fall_ev = !edge_src && edge_d_reg;
  wire clr_rise = wr_status && pwdata[`STAT_RISE_BIT];
  wire clr_fall = wr_status && pwdata[`STAT_FALL_BIT];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_d_reg <= 1'b0;
      rise_flag <= 1'b0;
      fall_flag <= 1'b0;
    end else begin
      edge_d_reg <= edge_src;
      // Set beats a same-cycle write-one-to-clear
      rise_flag <= rise_ev || (rise_flag && !clr_rise);
      fall_flag <= fall_ev || (fall_flag && !clr_fall);
    end
  end

  assign irq = (rise_flag && rise_irq_enable) || (fall_flag && fall_irq_enable);

  // ========================================================================
  // Read data
  wire [31:0] status_word = {26'h0, raw_compare_out, rise_irq_enable, fall_irq_enable,
                             rise_flag, fall_flag, filtered_out};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= hit_ctrl ? ctrl_reg :
                hit_period ? {24'h0, sample_period_div} :
                hit_status ? status_word : 32'h0000_0000;
    end
  end
endmodule // cmp_out_filter
`default_nettype wire

// file: verif/cmp_core_model.sv
// Behavioural model of the comparator core, window gate and sample source
`timescale 1ns/1ps
`default_nettype none
module cmp_core_model (
  input wire logic pclk,
  output logic compare_in,
  output logic window_in,
  output logic sample_in
);
  initial begin
    compare_in = 1'b0;
    window_in = 1'b0;
    sample_in = 1'b0;
  end
  task automatic drive(input logic c, input logic w);
    @(posedge pclk);
    compare_in <= c;
    window_in <= w;
  endtask
  // Sample strobe stays still outside commanded pulses
  task automatic strobe(input int hi);
    @(posedge pclk);
    sample_in <= 1'b1;
    repeat (hi) @(posedge pclk);
    sample_in <= 1'b0;
  endtask
endmodule // cmp_core_model
`default_nettype wire

// file: verif/cmp_out_filter_sva.sv
// Port-level checker of the comparator output filter
`timescale 1ns/1ps
`default_nettype none
`include "cmp_filter_defines.svh"
module cmp_out_filter_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic compare_in,
  input wire logic window_in,
  input wire logic raw_compare_out,
  input wire logic filtered_out,
  input wire logic irq
);
  // ==========================================================
  // Shadow of the configuration, rebuilt from bus writes
  logic [10:0] ctl;
  logic [7:0] per;
  logic [1:0] ie;
  logic [9:0] since;
  logic [3:0] wlo, whi;
  logic last_out;
  wire wr = psel & penable & pwrite;
  wire en = ctl[0];
  wire win = ctl[1];
  wire [2:0] cnt = ctl[10:8];
  wire cont = en & !win & !ctl[2] & (cnt == 3'h0 | per == 8'h00);
  wire filt = en & !win & !ctl[2] & cnt > 3'h1 & per != 8'h00;
  wire [9:0] lim = (cnt - 3'h1) * per;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl <= 11'h000;
      per <= 8'h00;
      ie <= 2'h0;
      since <= 10'h000;
      wlo <= 4'h0;
      whi <= 4'h0;
      last_out <= 1'b0;
    end else begin
      if (wr && paddr == `CTRL_OFFSET) ctl <= pwdata[10:0];
      if (wr && paddr == `PERIOD_OFFSET) per <= pwdata[7:0];
      if (wr && paddr == `STATUS_OFFSET) ie <= pwdata[4:3];
      last_out <= filtered_out;
      // Any write or output change restarts the spacing count
      since <= (wr || filtered_out != last_out) ? 10'h000 : since + {9'h0, since != 10'h3ff};
      wlo <= window_in ? 4'h0 : wlo + {3'h0, wlo != 4'hf};
      whi <= window_in ? whi + {3'h0, whi != 4'hf} : 4'h0;
    end
  end
  // ==========================================================
  // Properties
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_off_low; !en |-> !filtered_out && !raw_compare_out; endproperty
  a_off_low: assert property (p_off_low) else $error("output active while off");
  property p_cont; cont |-> filtered_out == raw_compare_out; endproperty
  a_cont: assert property (p_cont) else $error("continuous output not raw");
  property p_raw; en && !win |-> raw_compare_out == (compare_in ^ ctl[3]); endproperty
  a_raw: assert property (p_raw) else $error("raw output wrong");
  // Both now and before: a write that enters or leaves window mode may move the raw output
  property p_hold;
    en && win && $past(en & win) && wlo > 4'h4 |-> $stable(raw_compare_out);
  endproperty
  a_hold: assert property (p_hold) else $error("closed window changed raw");
  property p_pass;
    en && win && $past(en & win) && whi > 4'h4 && $stable(compare_in) |->
      raw_compare_out == (compare_in ^ ctl[3]);
  endproperty
  a_pass: assert property (p_pass) else $error("window latch too slow");
  property p_space; filt && $past(filt) && filtered_out != last_out |-> since >= lim; endproperty
  a_space: assert property (p_space) else $error("output changed too soon");
  property p_ie; ie == 2'h0 |-> !irq; endproperty
  a_ie: assert property (p_ie) else $error("irq without enable");
  property p_fall; $fell(irq) |-> $past(wr && paddr == `STATUS_OFFSET); endproperty
  a_fall: assert property (p_fall) else $error("irq dropped without clear");
endmodule // cmp_out_filter_sva
bind cmp_out_filter cmp_out_filter_sva chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .compare_in, .window_in, .raw_compare_out, .filtered_out, .irq);
`default_nettype wire

// file: verif/comparator_output_filter_tb.sv
// Self-checking bench of the comparator output filter
`timescale 1ns/1ps
`default_nettype none
`include "cmp_filter_defines.svh"
module comparator_output_filter_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic compare_in, window_in, sample_in, raw_compare_out, filtered_out, irq;
  int failures, num_checks, n;
  cmp_out_filter uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .compare_in, .window_in, .sample_in, .raw_compare_out, .filtered_out, .irq);
  cmp_core_model core (.pclk, .compare_in, .window_in, .sample_in);
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // ==========================================================
  // Bus and check helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Looks at the output only on falling edges, where it has settled
  task automatic wait_out(input logic v);
    n = 0;
    @(negedge pclk);
    while (filtered_out !== v && n < 200) begin
      @(negedge pclk);
      n++;
    end
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs;
    apb(0, `STATUS_OFFSET, 32'h0);
    check(rd, 32'h0);
    apb(0, 12'h00c, 32'h0);
    check(rd, 32'h0);
    check({31'h0, err}, 32'h1);
    $display("t_regs done");
  endtask
  task automatic t_cont;
    apb(1, `CTRL_OFFSET, 32'h1);
    core.drive(1, 0);
    @(negedge pclk);
    check({filtered_out, raw_compare_out}, 2'b11);
    apb(1, `CTRL_OFFSET, 32'h9);
    @(negedge pclk);
    check({filtered_out, raw_compare_out}, 2'b00);
    $display("t_cont done");
  endtask
  task automatic t_filter;
    apb(1, `CTRL_OFFSET, 32'h0);
    // Drop edge flags left over from the continuous run
    apb(1, `STATUS_OFFSET, 32'h6);
    apb(1, `PERIOD_OFFSET, 32'h4);
    apb(1, `CTRL_OFFSET, 32'h301);
    repeat (8) @(negedge pclk);
    check(filtered_out, 0);
    wait_out(1);
    check(n > 0 && n <= 3 * 4 + 6, 1);
    core.drive(0, 0);
    repeat (5) @(posedge pclk);
    core.drive(1, 0);
    repeat (30) @(negedge pclk);
    check(filtered_out, 1);
    core.drive(0, 0);
    wait_out(0);
    check(n > 7 && n <= 3 * 4 + 6, 1);
    apb(0, `STATUS_OFFSET, 32'h0);
    check(rd, 32'h6);
    // Request follows the register write, so look once it has settled
    apb(1, `STATUS_OFFSET, 32'h10);
    @(negedge pclk);
    check(irq, 1);
    apb(1, `STATUS_OFFSET, 32'h14);
    @(negedge pclk);
    check(irq, 0);
    apb(1, `STATUS_OFFSET, 32'h08);
    @(negedge pclk);
    check(irq, 1);
    apb(1, `STATUS_OFFSET, 32'h02);
    @(negedge pclk);
    check(irq, 0);
    $display("t_filter done");
  endtask
  task automatic t_ext;
    apb(1, `CTRL_OFFSET, 32'h0);
    apb(1, `PERIOD_OFFSET, 32'h0);
    apb(1, `CTRL_OFFSET, 32'h105);
    core.drive(1, 0);
    repeat (20) @(negedge pclk);
    check(filtered_out, 0);
    core.strobe(4);
    repeat (8) @(negedge pclk);
    check(filtered_out, 1);
    $display("t_ext done");
  endtask
  task automatic t_window;
    apb(1, `CTRL_OFFSET, 32'h0);
    apb(1, `CTRL_OFFSET, 32'h3);
    core.drive(1, 1);
    repeat (8) @(negedge pclk);
    check(raw_compare_out, 1);
    core.drive(1, 0);
    repeat (6) @(posedge pclk);
    core.drive(0, 0);
    repeat (8) @(negedge pclk);
    check(raw_compare_out, 1);
    apb(1, `CTRL_OFFSET, 32'h0);
    apb(1, `PERIOD_OFFSET, 32'h2);
    apb(1, `CTRL_OFFSET, 32'h203);
    core.drive(1, 1);
    wait_out(1);
    check(n > 0 && n <= 2 * 2 + 9, 1);
    $display("t_window done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_cont();
    t_filter();
    t_ext();
    t_window();
    report_and_stop();
  end
  // Whole run is a few hundred cycles
  initial begin
    #50us;
    failures++;
    report_and_stop();
  end
endmodule // comparator_output_filter_tb
`default_nettype wire
